// ===== rtl/nvm_byte_access_control.sv
// Access control for data EEPROM bytes and program memory words, seen by the core as registers.
// Assumes an asynchronous-read EEPROM array, a program fetch port sampled in its slot,
// and a write-done pulse from the array.
//
// Behaviour
// [RULE1] - Firmware reads data: load low address, clear space select, set read strobe.
// [RULE2] - Data read result lands in low data register the very next cycle.
// [RULE3] - Read result stays until another read or a firmware write.
// [RULE4] - Firmware loads address and data registers before starting a write.
// [RULE5] - Write starts only after 55h then AAh to unlock port, then strobe.
// [RULE6] - Firmware should mask interrupts across the unlock sequence.
// [RULE7] - Write strobe cannot be set while write permit is clear.
// [RULE8] - Hardware never clears write permit; only firmware changes it.
// [RULE9] - Clearing write permit mid-cycle does not disturb the running write.
// [RULE10] - Write completion clears write strobe and sets write-complete flag.
// [RULE11] - Write-complete flag stays set until firmware clears it.
// [RULE12] - Firmware should keep write permit clear except while updating.
// [RULE13] - Firmware reads program memory: load both addresses, set space select, strobe.
// [RULE14] - Program read fetches in second cycle after strobe; that instruction is discarded.
// [RULE15] - Fetched word appears in both data registers next cycle and is held.
// [RULE16] - Firmware places two no-ops after a program read strobe.
// [RULE17] - Write strobe with program space selected clears at once, does nothing.
// [RULE18] - Abort flag sets when a reset cuts a write short, clears on completion.
// [RULE19] - Read strobe is set only by firmware, cleared only by hardware.
// [RULE20] - Write permit clears at power-up; writes blocked during 64 ms timer.
// [RULE21] - Unlock detector re-arms on any out-of-sequence port or strobe access.
`timescale 1ns/1ns
module nvm_byte_access_control
#(
	parameter int unsigned PWRUP_CYCLES = nvm_pkg::PWRUP_CYCLES
)
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire logic core_restart_i,
	input wire nvm_pkg::reg_req_s reg_req_i,
	output logic [7:0] reg_rdata_o,
	output nvm_pkg::ee_req_s ee_req_o,
	input wire logic [7:0] ee_rdata_i,
	input wire logic ee_wr_done_i,
	output nvm_pkg::pm_req_s pm_req_o,
	input wire logic [nvm_pkg::PROG_WORD_W-1:0] pm_rdata_i,
	output logic discard_instr_o,
	output logic program_done_o,
	output logic write_busy_o
);
	import nvm_pkg::*;

	function automatic logic hit(input reg_req_s req, input logic [8:0] addr);
		hit = req.wr && (req.addr == addr);
	endfunction

	logic [7:0] addr_low_r;
	logic [7:0] addr_high_r;
	logic [7:0] data_low_r;
	logic [PROG_HIGH_W-1:0] data_high_r;
	logic space_select_r;
	logic program_permit_r;
	logic program_abort_flag_r;
	logic program_done_flag_r;
	logic wr_r;
	logic [7:0] wr_addr_r;
	logic [7:0] wr_data_r;
	logic [PWRUP_W-1:0] pwrup_cnt_r;
	pm_read_e pm_state_r;
	logic [7:0] reg_rdata_r;

	logic ctrl_wr;
	logic port_wr;
	logic armed;
	logic pwrup_done;
	logic rd_request;
	logic data_rd_start;
	logic pm_rd_start;
	logic wr_start;
	logic wr_finish;
	logic wr_cut;

	assign ctrl_wr = hit(reg_req_i, ADDR_ACCESS_CONTROL);
	assign port_wr = hit(reg_req_i, ADDR_UNLOCK_PORT);
	assign pwrup_done = (pwrup_cnt_r == '0);

	// Read strobe only acts on a written one; a written zero is ignored
	assign rd_request = ctrl_wr && reg_req_i.wdata[BIT_READ] && (pm_state_r == PM_IDLE); // [RULE19]
	assign data_rd_start = rd_request && !reg_req_i.wdata[BIT_SPACE_SELECT]; // [RULE1]
	assign pm_rd_start = rd_request && reg_req_i.wdata[BIT_SPACE_SELECT]; // [RULE13]

	// Data space only; program space strobe is dropped and never stored
	assign wr_start = ctrl_wr && reg_req_i.wdata[BIT_WRITE] && !reg_req_i.wdata[BIT_SPACE_SELECT] // [RULE17]
		&& armed && program_permit_r && pwrup_done && !wr_r && !rd_request; // [RULE5] [RULE7] [RULE20]
	assign wr_finish = wr_r && ee_wr_done_i;
	assign wr_cut = wr_r && core_restart_i;

	nvm_unlock_seq u_unlock
	(
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.clk_en_i(clk_en_i),
		.port_wr_i(port_wr),
		.port_data_i(reg_req_i.wdata),
		.strobe_touch_i(ctrl_wr),
		.armed_o(armed)
	);

	// Power-up lockout; long count, so a simulation can shorten it
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			pwrup_cnt_r <= PWRUP_W'(PWRUP_CYCLES - 1);
		else if (clk_en_i && !pwrup_done)
			pwrup_cnt_r <= pwrup_cnt_r - PWRUP_W'(1); // [RULE20]
	end

	// Address registers, firmware owned
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			addr_low_r <= BYTE_RESET;
			addr_high_r <= BYTE_RESET;
		end
		else if (clk_en_i)
		begin
			if (hit(reg_req_i, ADDR_ADDR_LOW))
				addr_low_r <= reg_req_i.wdata;
			if (hit(reg_req_i, ADDR_ADDR_HIGH))
				addr_high_r <= reg_req_i.wdata;
		end
	end

	// Data registers: a read result wins over a firmware write in its cycle, which only the program fetch slot
	// can meet, since the core makes one access per cycle; results hold until the next read or a firmware write
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			data_low_r <= BYTE_RESET;
			data_high_r <= HIGH_DATA_RESET;
		end
		else if (clk_en_i)
		begin
			if (data_rd_start)
				data_low_r <= ee_rdata_i; // [RULE2] [RULE3]
			else if (pm_state_r == PM_FETCH && !core_restart_i)
			begin
				data_low_r <= pm_rdata_i[7:0]; // [RULE15]
				data_high_r <= pm_rdata_i[PROG_WORD_W-1:8]; // [RULE15]
			end
			else
			begin
				if (hit(reg_req_i, ADDR_DATA_LOW))
					data_low_r <= reg_req_i.wdata; // [RULE3]
				if (hit(reg_req_i, ADDR_DATA_HIGH))
					data_high_r <= reg_req_i.wdata[PROG_HIGH_W-1:0];
			end
		end
	end

	// Space select and write permit; permit is never touched by hardware
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			space_select_r <= 1'b0;
			program_permit_r <= 1'b0; // [RULE20]
		end
		else if (clk_en_i && ctrl_wr)
		begin
			space_select_r <= reg_req_i.wdata[BIT_SPACE_SELECT];
			program_permit_r <= reg_req_i.wdata[BIT_PERMIT]; // [RULE8]
		end
	end

	// Program read timing: strobe, one normal instruction, then the fetch slot
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			pm_state_r <= PM_IDLE;
		else if (clk_en_i)
		begin
			if (core_restart_i)
				pm_state_r <= PM_IDLE;
			else
			begin
				unique case (pm_state_r)
					PM_IDLE:
					begin
						if (pm_rd_start)
							pm_state_r <= PM_WAIT; // [RULE14]
					end
					PM_WAIT: pm_state_r <= PM_FETCH; // [RULE14]
					PM_FETCH: pm_state_r <= PM_IDLE; // [RULE19]
					default: pm_state_r <= PM_IDLE;
				endcase
			end
		end
	end

	// Write cycle; address and data are latched so later firmware writes
	// and a cleared permit cannot change a running cycle
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wr_r <= 1'b0;
			wr_addr_r <= BYTE_RESET;
			wr_data_r <= BYTE_RESET;
		end
		else if (clk_en_i)
		begin
			if (wr_start)
			begin
				wr_r <= 1'b1; // [RULE5]
				wr_addr_r <= addr_low_r;
				wr_data_r <= data_low_r;
			end
			else if (wr_finish || wr_cut)
				wr_r <= 1'b0; // [RULE10] [RULE9]
		end
	end

	// Abort flag: hardware events win over a firmware write in the same cycle
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			program_abort_flag_r <= 1'b0;
		else if (clk_en_i)
		begin
			if (wr_cut)
				program_abort_flag_r <= 1'b1; // [RULE18]
			else if (wr_finish)
				program_abort_flag_r <= 1'b0; // [RULE18]
			else if (ctrl_wr)
				program_abort_flag_r <= reg_req_i.wdata[BIT_ABORT];
		end
	end

	// Completion flag: set wins over a clear in the same cycle
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			program_done_flag_r <= 1'b0;
		else if (clk_en_i)
		begin
			if (wr_finish && !core_restart_i)
				program_done_flag_r <= 1'b1; // [RULE10]
			else if (hit(reg_req_i, ADDR_EVENT_FLAGS))
				program_done_flag_r <= reg_req_i.wdata[BIT_DONE]; // [RULE11]
		end
	end

	// Register read port, one cycle after the request
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			reg_rdata_r <= BYTE_RESET;
		else if (clk_en_i && reg_req_i.rd)
		begin
			unique case (reg_req_i.addr)
				ADDR_DATA_LOW: reg_rdata_r <= data_low_r;
				ADDR_ADDR_LOW: reg_rdata_r <= addr_low_r;
				ADDR_DATA_HIGH: reg_rdata_r <= {{(8 - PROG_HIGH_W){1'b0}}, data_high_r};
				ADDR_ADDR_HIGH: reg_rdata_r <= addr_high_r;
				ADDR_ACCESS_CONTROL: reg_rdata_r <= {space_select_r, 3'b000, program_abort_flag_r,
					program_permit_r, wr_r, (pm_state_r != PM_IDLE)};
				ADDR_EVENT_FLAGS: reg_rdata_r <= {3'b000, program_done_flag_r, 4'b0000};
				default: reg_rdata_r <= BYTE_RESET;
			endcase
		end
	end

	assign reg_rdata_o = reg_rdata_r;

	// Array side: read is asynchronous and captured at the strobe edge
	assign ee_req_o.rd = clk_en_i && data_rd_start; // [RULE2]
	assign ee_req_o.wr = wr_r; // [RULE9]
	assign ee_req_o.addr = wr_r ? wr_addr_r : addr_low_r;
	assign ee_req_o.wdata = wr_data_r;

	assign pm_req_o.fetch = (pm_state_r == PM_FETCH); // [RULE14]
	assign pm_req_o.addr = {addr_high_r, addr_low_r};

	// The instruction in the fetch slot must be thrown away by the core
	assign discard_instr_o = (pm_state_r == PM_FETCH); // [RULE14]
	assign program_done_o = program_done_flag_r;
	assign write_busy_o = wr_r;

endmodule

// ===== rtl/nvm_pkg.sv
// Constants, field positions and carrier types for the byte-wide NVM access block.
// Assumes the core runs one instruction per core_clk_i cycle.
package nvm_pkg;

	// Register addresses in the core's register space
	localparam logic [8:0] ADDR_DATA_LOW = 9'h10c;
	localparam logic [8:0] ADDR_ADDR_LOW = 9'h10d;
	localparam logic [8:0] ADDR_DATA_HIGH = 9'h10e;
	localparam logic [8:0] ADDR_ADDR_HIGH = 9'h10f;
	localparam logic [8:0] ADDR_ACCESS_CONTROL = 9'h18c;
	localparam logic [8:0] ADDR_UNLOCK_PORT = 9'h18d;
	localparam logic [8:0] ADDR_EVENT_FLAGS = 9'h00d;

	// Field positions
	localparam int BIT_SPACE_SELECT = 7;
	localparam int BIT_ABORT = 3;
	localparam int BIT_PERMIT = 2;
	localparam int BIT_WRITE = 1;
	localparam int BIT_READ = 0;
	localparam int BIT_DONE = 4;

	// Unlock keys
	localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
	localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;

	// Values after reset
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [5:0] HIGH_DATA_RESET = 6'h00;

	// Program word width; the high data register holds the upper bits
	localparam int PROG_WORD_W = 14;
	localparam int PROG_HIGH_W = PROG_WORD_W - 8;

	// Power-up write lockout
	localparam int CLK_HZ = 25_000_000;
	localparam int PWRUP_TIME_MS = 64;
	localparam int PWRUP_CYCLES = PWRUP_TIME_MS * (CLK_HZ / 1000);
	localparam int PWRUP_W = 21;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [8:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ee_req_s;

	typedef struct packed {
		logic fetch;
		logic [15:0] addr;
	} pm_req_s;

	typedef enum logic [1:0] {
		UNLOCK_IDLE,
		UNLOCK_FIRST,
		UNLOCK_ARMED
	} unlock_e;

	typedef enum logic [1:0] {
		PM_IDLE,
		PM_WAIT,
		PM_FETCH
	} pm_read_e;

endpackage

// ===== rtl/nvm_unlock_seq.sv
// Two-key unlock detector in front of the write strobe.
// Assumes port and strobe accesses arrive as one-cycle write pulses.
`timescale 1ns/1ns
module nvm_unlock_seq
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire logic port_wr_i,
	input wire logic [7:0] port_data_i,
	input wire logic strobe_touch_i,
	output logic armed_o
);
	import nvm_pkg::*;

	unlock_e state_r;

	// Any step out of order drops straight back to idle
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			state_r <= UNLOCK_IDLE;
		else if (clk_en_i)
		begin
			unique case (state_r)
				UNLOCK_IDLE:
				begin
					if (port_wr_i && port_data_i == UNLOCK_KEY_FIRST)
						state_r <= UNLOCK_FIRST; // [RULE5]
				end
				UNLOCK_FIRST:
				begin
					if (port_wr_i)
						state_r <= (port_data_i == UNLOCK_KEY_SECOND) ? UNLOCK_ARMED : UNLOCK_IDLE; // [RULE5] [RULE21]
					else if (strobe_touch_i)
						state_r <= UNLOCK_IDLE; // [RULE21]
				end
				UNLOCK_ARMED:
				begin
					// Armed for exactly one strobe access
					if (port_wr_i || strobe_touch_i)
						state_r <= UNLOCK_IDLE; // [RULE5] [RULE21]
				end
				default: state_r <= UNLOCK_IDLE;
			endcase
		end
	end

	assign armed_o = (state_r == UNLOCK_ARMED);

endmodule

// ===== sim/nvm_array_model.sv
// Behavioural EEPROM array and program store facing the access block.
// Assumes requests shaped as the block drives them; a write finishes after WR_LAT+1 cycles of the write request.
`timescale 1ns/1ns
module nvm_array_model
import nvm_pkg::*;
#(
	parameter int WR_LAT = 4
)
(
	input wire logic core_clk_i,
	input wire nvm_pkg::ee_req_s ee_req_i,
	input wire nvm_pkg::pm_req_s pm_req_i,
	output logic [7:0] ee_rdata_o,
	output logic ee_wr_done_o = 1'b0,
	output logic [nvm_pkg::PROG_WORD_W-1:0] pm_rdata_o
);
	logic [7:0] mem [256];
	logic [13:0] pw;
	int cnt = 0;
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h3c;
	end
	// Outside a read the lines carry the inverse, so a stale sample never looks right
	assign ee_rdata_o = ee_req_i.rd ? mem[ee_req_i.addr] : ~mem[ee_req_i.addr];
	assign pw = {pm_req_i.addr[13:8] ^ 6'h15, pm_req_i.addr[7:0]};
	assign pm_rdata_o = pm_req_i.fetch ? pw : ~pw;
	always @(posedge core_clk_i)
	begin
		ee_wr_done_o <= 1'b0;
		if (!ee_req_i.wr)
			cnt <= 0;
		else if (cnt <= WR_LAT)
			cnt <= cnt + 1;
		if (ee_req_i.wr && cnt == WR_LAT)
		begin
			mem[ee_req_i.addr] <= ee_req_i.wdata;
			ee_wr_done_o <= 1'b1;
		end
	end
endmodule

// ===== sim/nvm_access_properties.sv
// Port-level checks of the NVM access block.
// Assumes one clock domain; bound to every instance of the block.
`timescale 1ns/1ns
module nvm_access_properties
import nvm_pkg::*;
#(
	parameter int unsigned PWRUP_CYCLES = 8
)
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire logic core_restart_i,
	input wire nvm_pkg::reg_req_s reg_req_i,
	input wire logic [7:0] reg_rdata_o,
	input wire nvm_pkg::ee_req_s ee_req_o,
	input wire logic ee_wr_done_i,
	input wire nvm_pkg::pm_req_s pm_req_o,
	input wire logic discard_instr_o,
	input wire logic program_done_o,
	input wire logic write_busy_o
);
	logic run, ctl, k1, k2, prd, drd;
	logic [7:0] d;
	assign d = reg_req_i.wdata;
	assign run = clk_en_i && !core_restart_i;
	assign ctl = run && reg_req_i.wr && reg_req_i.addr == ADDR_ACCESS_CONTROL;
	assign k1 = run && reg_req_i.wr && reg_req_i.addr == ADDR_UNLOCK_PORT && d == UNLOCK_KEY_FIRST;
	assign k2 = run && reg_req_i.wr && reg_req_i.addr == ADDR_UNLOCK_PORT && d == UNLOCK_KEY_SECOND;
	assign prd = ctl && d[BIT_SPACE_SELECT] && d[BIT_READ] && !discard_instr_o;
	assign drd = ctl && !d[BIT_SPACE_SELECT] && d[BIT_READ] && !discard_instr_o;
	// Cycles since release, frozen with the block, so the lockout window matches its timer
	logic [31:0] up_cnt;
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			up_cnt <= '0;
		else if (clk_en_i && up_cnt < PWRUP_CYCLES)
			up_cnt <= up_cnt + 32'd1;
	end
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence s_pm_rd;
		prd ##1 run;
	endsequence
	sequence s_finish;
		write_busy_o && ee_wr_done_i && run;
	endsequence
	chk_wr_start: assert property ($rose(write_busy_o) |-> $past(ctl) && $past(k2, 2) && $past(k1, 3))
		else $error("write started without unlock");
	chk_done_set: assert property (s_finish |=> !write_busy_o && program_done_o)
		else $error("completion did not clear busy or set done");
	chk_busy_holds: assert property (write_busy_o && !ee_wr_done_i && !core_restart_i |=> write_busy_o)
		else $error("write ended early");
	chk_pm_fetch: assert property (s_pm_rd |-> ##1 pm_req_o.fetch && discard_instr_o)
		else $error("program fetch slot missing");
	chk_data_rd: assert property (drd |-> ee_req_o.rd)
		else $error("data read not issued");
	chk_pgm_no_wr: assert property (ctl && d[BIT_SPACE_SELECT] && !write_busy_o |=> !write_busy_o)
		else $error("write began with program space");
	chk_rdata_hold: assert property (!(reg_req_i.rd && clk_en_i) |=> $stable(reg_rdata_o))
		else $error("read data changed without a read");
	chk_cut_write: assert property (write_busy_o && core_restart_i && clk_en_i |=> !write_busy_o)
		else $error("restart did not cut the write");
	chk_pwrup_lock: assert property (up_cnt < PWRUP_CYCLES |-> !write_busy_o)
		else $error("write ran during power-up lockout");
endmodule
bind nvm_byte_access_control nvm_access_properties #(.PWRUP_CYCLES(PWRUP_CYCLES)) chk_u (.core_clk_i, .reset_n_i,
	.clk_en_i, .core_restart_i, .reg_req_i, .reg_rdata_o, .ee_req_o, .ee_wr_done_i, .pm_req_o, .discard_instr_o,
	.program_done_o, .write_busy_o);

// ===== sim/tb.sv
// Self-checking bench for the NVM access block with a behavioural array.
// Assumes the bench acts as the core: one register access per cycle, driven on falling edges.
`timescale 1ns/1ns
module tb;
	import nvm_pkg::*;
	localparam int unsigned PWR = 40;
	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic clk_en_i = 1'b1;
	logic core_restart_i = 1'b0;
	reg_req_s req = '0;
	ee_req_s ee_req;
	pm_req_s pm_req;
	logic [7:0] rdata, ee_rdata;
	logic [PROG_WORD_W-1:0] pm_rdata;
	logic ee_done, discard, done, busy;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	initial
	begin
		forever #20 core_clk_i = ~core_clk_i;
	end
	nvm_byte_access_control #(.PWRUP_CYCLES(PWR)) dut_u (.core_clk_i, .reset_n_i, .clk_en_i, .core_restart_i,
		.reg_req_i(req), .reg_rdata_o(rdata), .ee_req_o(ee_req), .ee_rdata_i(ee_rdata), .ee_wr_done_i(ee_done),
		.pm_req_o(pm_req), .pm_rdata_i(pm_rdata), .discard_instr_o(discard), .program_done_o(done), .write_busy_o(busy));
	nvm_array_model mem_u (.core_clk_i, .ee_req_i(ee_req), .pm_req_i(pm_req), .ee_rdata_o(ee_rdata),
		.ee_wr_done_o(ee_done), .pm_rdata_o(pm_rdata));
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Strobes stay up between calls so no signal is assigned twice in one step
	task automatic acc(logic w, logic r, logic [8:0] a, logic [7:0] d);
		req = '{w, r, a, d};
		@(negedge core_clk_i);
	endtask
	task automatic idle(int n);
		repeat (n) acc(1'b0, 1'b0, 9'h000, 8'h00);
	endtask
	task automatic rd(logic [8:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
		acc(1'b0, 1'b1, a, 8'h00);
		chk(rdata & m, e);
	endtask
	task automatic wr(logic [8:0] a, logic [7:0] d);
		acc(1'b1, 1'b0, a, d);
	endtask
	task automatic start(logic [7:0] ctl);
		wr(ADDR_UNLOCK_PORT, UNLOCK_KEY_FIRST);
		wr(ADDR_UNLOCK_PORT, UNLOCK_KEY_SECOND);
		wr(ADDR_ACCESS_CONTROL, ctl);
		idle(1);
	endtask
	// f carries extra control bits, so a pending abort flag can survive the set-up writes
	task automatic go(logic [7:0] a, logic [7:0] d, logic [7:0] f = 8'h00);
		wr(ADDR_ADDR_LOW, a);
		wr(ADDR_DATA_LOW, d);
		wr(ADDR_ACCESS_CONTROL, 8'h04 | f);
		start(8'h06 | f);
		chk({7'h00, busy}, 8'h01);
	endtask
	task automatic fin();
		for (int i = 0; i < 20 && done !== 1'b1; i++)
			idle(1);
		chk({6'h00, done, busy}, 8'h02);
	endtask
	task automatic t_pwrup();
		rd(ADDR_ACCESS_CONTROL, 8'h00);
		rd(ADDR_EVENT_FLAGS, 8'h00);
		rd(ADDR_UNLOCK_PORT, 8'h00);
		rd(9'h1ff, 8'h00);
		wr(ADDR_ACCESS_CONTROL, 8'h04);
		start(8'h06);
		chk({7'h00, busy}, 8'h00);
		rd(ADDR_ACCESS_CONTROL, 8'h04);
		wr(ADDR_ACCESS_CONTROL, 8'h00);
		idle(PWR);
		$display("test pwrup done");
	endtask
	task automatic t_data_rd();
		wr(ADDR_ADDR_LOW, 8'h21);
		wr(ADDR_ACCESS_CONTROL, 8'h01);
		rd(ADDR_DATA_LOW, 8'h21 ^ 8'h3c);
		wr(ADDR_ACCESS_CONTROL, 8'h00);
		rd(ADDR_ACCESS_CONTROL, 8'h00);
		idle(3);
		rd(ADDR_DATA_LOW, 8'h21 ^ 8'h3c);
		$display("test data read done");
	endtask
	task automatic t_write();
		go(8'h40, 8'h99);
		wr(ADDR_ACCESS_CONTROL, 8'h00);
		fin();
		chk(mem_u.mem[8'h40], 8'h99);
		idle(3);
		rd(ADDR_EVENT_FLAGS, 8'h10);
		wr(ADDR_EVENT_FLAGS, 8'h00);
		rd(ADDR_EVENT_FLAGS, 8'h00);
		$display("test write done");
	endtask
	task automatic t_refuse();
		logic [7:0] pre [3] = '{8'h04, 8'h00, 8'h84};
		for (int i = 0; i < 3; i++)
		begin
			wr(ADDR_ACCESS_CONTROL, pre[i]);
			if (i == 0)
				wr(ADDR_UNLOCK_PORT, UNLOCK_KEY_FIRST);
			start(pre[i] | 8'h02);
			chk({7'h00, busy}, 8'h00);
		end
		$display("test refusals done");
	endtask
	task automatic t_prog_rd();
		wr(ADDR_ADDR_HIGH, 8'h12);
		wr(ADDR_ADDR_LOW, 8'h34);
		wr(ADDR_ACCESS_CONTROL, 8'h81);
		idle(1);
		chk({7'h00, discard}, 8'h01);
		idle(1);
		chk({7'h00, discard}, 8'h00);
		rd(ADDR_DATA_LOW, 8'h34);
		rd(ADDR_DATA_HIGH, 8'h07);
		rd(ADDR_ACCESS_CONTROL, 8'h00, 8'h01);
		$display("test program read done");
	endtask
	task automatic t_abort();
		go(8'h41, 8'h5a);
		core_restart_i = 1'b1;
		@(negedge core_clk_i);
		core_restart_i = 1'b0;
		chk({6'h00, done, busy}, 8'h00);
		rd(ADDR_ACCESS_CONTROL, 8'h08, 8'h08);
		go(8'h42, 8'h66, 8'h08);
		rd(ADDR_ACCESS_CONTROL, 8'h08, 8'h08);
		fin();
		rd(ADDR_ACCESS_CONTROL, 8'h00, 8'h08);
		$display("test abort done");
	endtask
	task automatic t_freeze();
		wr(ADDR_ADDR_LOW, 8'h5c);
		clk_en_i = 1'b0;
		wr(ADDR_ADDR_LOW, 8'ha3);
		wr(ADDR_ACCESS_CONTROL, 8'h01);
		clk_en_i = 1'b1;
		rd(ADDR_ADDR_LOW, 8'h5c);
		rd(ADDR_ADDR_HIGH, 8'h12);
		rd(ADDR_DATA_LOW, 8'h66);
		rd(ADDR_ACCESS_CONTROL, 8'h04, 8'h05);
		$display("test freeze done");
	endtask
	initial
	begin
		repeat (5) @(negedge core_clk_i);
		reset_n_i = 1'b1;
		t_pwrup();
		t_data_rd();
		t_write();
		t_refuse();
		t_prog_rd();
		t_abort();
		t_freeze();
		results();
	end
	always @(posedge core_clk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			results();
		end
	end
endmodule
